// ### clk_ratio_consts.vh
// Constants for the system clock ratio control block
`ifndef CLK_RATIO_CONSTS_VH
`define CLK_RATIO_CONSTS_VH

// ----------------------------------------
// Register byte offsets
// ----------------------------------------
`define OFF_SYSTEM_CLOCK_CONTROL_REGISTER_UNITS 12'h000
`define OFF_LB_RATIO 12'h004
`define OFF_ENGINE_CFG 12'h008
`define OFF_ENGINE_FREQ 12'h00c
`define OFF_STATUS 12'h010

// ----------------------------------------
// Unit clock selection codes
// ----------------------------------------
`define SEL_CSB 2'h0
`define SEL_OFF 2'h1
`define SEL_DIV2 2'h2
`define SEL_DIV3 2'h3

// ----------------------------------------
// Field positions in the unit control register
// ----------------------------------------
`define F_SEC_LSB 0
`define F_I2C_LSB 2
`define F_AUXA_LSB 4
`define F_AUXB_LSB 6
`define F_PCI_BIT 8

// ----------------------------------------
// Reset values
// ----------------------------------------
`define RST_UNITS 9'h000
`define RST_LB_DIV 4'h2
`define RST_MULT 6'h04
`define RST_DIV 2'h0

// ----------------------------------------
// Frequency limits in MHz
// ----------------------------------------
`define MAX_CORE_MHZ 16'h014d
`define MAX_CSB_MHZ 16'h0085
`define MAX_ENGINE_MHZ 16'h00c8

`endif

// ### lb_clk_div.v
// Local bus clock divider with even and odd ratios
`timescale 1ns/10ps
`default_nettype none

module lb_clk_div #(
  parameter WIDTH = 4
) (
  // Clock and reset
  input wire clk_in,
  input wire resetn_in,
  // Ratio, values below 2 act as 2
  input wire [WIDTH-1:0] div_in,
  // Divided clock level
  output reg clk_div_out
);

  reg [WIDTH-1:0] cnt_r;
  reg [WIDTH-1:0] div_r;
  wire [WIDTH-1:0] eff;

  assign eff = (div_in < 2) ? {{(WIDTH-2){1'b0}}, 2'b10} : div_in;

  // ----------------------------------------
  // Counter
  // ----------------------------------------
  // Ratio reloaded only at period end to avoid short pulses
  always @(posedge clk_in or negedge resetn_in) begin
    if (!resetn_in) begin
      cnt_r <= {WIDTH{1'b0}};
      div_r <= {{(WIDTH-2){1'b0}}, 2'b10};
      clk_div_out <= 1'b0;
    end else begin
      if (cnt_r == div_r - 1'b1) begin
        cnt_r <= {WIDTH{1'b0}};
        div_r <= eff;
        clk_div_out <= 1'b1;
      end else begin
        cnt_r <= cnt_r + 1'b1;
        if (cnt_r == (div_r >> 1) - 1'b1)
          clk_div_out <= 1'b0;
      end
    end
  end

endmodule // lb_clk_div
`default_nettype wire

// ### pll_model.sv
// Model of the PLL that feeds the memory controller clock
`timescale 1ns/10ps
`default_nettype none
module pll_model (
  // Double-rate clock
  output logic mem_clk_out
);
  initial mem_clk_out = 1'h0;
  // twice bus rate
  // Offset from the bus edges so no sample races
  always #5 mem_clk_out = ~mem_clk_out;
endmodule // pll_model
`default_nettype wire

// ### sys_clk_chk.sv
// Assertion checker for the clock ratio control block
`timescale 1ns/10ps
`default_nettype none
`include "clk_ratio_consts.vh"
module sys_clk_chk (
  // Clocks and reset
  input wire logic clk_in,
  input wire logic resetn_in,
  input wire logic mem_ctrl_clk_in,
  // Register bus
  input wire logic psel_in,
  input wire logic penable_in,
  input wire logic pwrite_in,
  input wire logic [11:0] paddr_in,
  input wire logic [31:0] pwdata_in,
  input wire logic pready_out,
  input wire logic pslverr_out,
  // Clock outputs
  input wire logic memory_bus_clock_out,
  input wire logic memory_bus_clock_n_out,
  input wire logic mem_data_strobe_out,
  input wire logic lbc_clk_en_out,
  input wire logic local_bus_sync_clock_out,
  input wire logic [2:0] local_bus_clock_outs,
  input wire logic pci_dma_clk_en_out
);
  wire logic unit_wr;
  assign unit_wr = psel_in && penable_in && pwrite_in &&
                   paddr_in == `OFF_SYSTEM_CLOCK_CONTROL_REGISTER_UNITS;
  AST_MBC_PAIR: assert property (@(posedge mem_ctrl_clk_in)
    disable iff (!resetn_in) memory_bus_clock_n_out == !memory_bus_clock_out)
    else $error("memory bus clock pair not complementary");
  AST_MBC_HALF: assert property (@(posedge mem_ctrl_clk_in)
    disable iff (!resetn_in) $past(resetn_in) |->
    memory_bus_clock_out != $past(memory_bus_clock_out))
    else $error("memory bus clock not half of controller clock");
  AST_STROBE: assert property (@(posedge mem_ctrl_clk_in)
    disable iff (!resetn_in) $past(resetn_in) |-> mem_data_strobe_out)
    else $error("data strobe missing in a controller cycle");
  AST_LB_SAME: assert property (@(posedge clk_in)
    disable iff (!resetn_in)
    local_bus_clock_outs == {3{local_bus_sync_clock_out}})
    else $error("local bus clocks differ");
  AST_LBC_RUN: assert property (@(posedge clk_in)
    disable iff (!resetn_in) lbc_clk_en_out)
    else $error("local bus controller clock stopped");
  AST_PCI_OFF: assert property (@(posedge clk_in)
    disable iff (!resetn_in) unit_wr && pwdata_in[8] |->
    ##[1:2] !pci_dma_clk_en_out)
    else $error("pci clock not switched off");
  AST_PCI_ON: assert property (@(posedge clk_in)
    disable iff (!resetn_in) unit_wr && !pwdata_in[8] |->
    ##[1:2] pci_dma_clk_en_out)
    else $error("pci clock not running");
  AST_READY: assert property (@(posedge clk_in)
    disable iff (!resetn_in) psel_in && penable_in |-> pready_out)
    else $error("access phase stalled");
  AST_SLVERR: assert property (@(posedge clk_in)
    disable iff (!resetn_in) psel_in && penable_in && paddr_in[1:0] == 2'h0
    |-> pslverr_out == (paddr_in > `OFF_STATUS))
    else $error("error response wrong for address");
endmodule // sys_clk_chk
bind system_clock_ratio_control sys_clk_chk i_sys_clk_chk (
  .clk_in(clk_in),
  .resetn_in(resetn_in),
  .mem_ctrl_clk_in(mem_ctrl_clk_in),
  .psel_in(psel_in),
  .penable_in(penable_in),
  .pwrite_in(pwrite_in),
  .paddr_in(paddr_in),
  .pwdata_in(pwdata_in),
  .pready_out(pready_out),
  .pslverr_out(pslverr_out),
  .memory_bus_clock_out(memory_bus_clock_out),
  .memory_bus_clock_n_out(memory_bus_clock_n_out),
  .mem_data_strobe_out(mem_data_strobe_out),
  .lbc_clk_en_out(lbc_clk_en_out),
  .local_bus_sync_clock_out(local_bus_sync_clock_out),
  .local_bus_clock_outs(local_bus_clock_outs),
  .pci_dma_clk_en_out(pci_dma_clk_en_out)
);
`default_nettype wire

// ### system_clock_ratio_control.v
// Clock ratio and gating control with APB register access
//
// The register addresses and the APB interface to the registers were chosen for this implementation.
`timescale 1ns/10ps
`default_nettype none
`include "clk_ratio_consts.vh"

module system_clock_ratio_control #(
  parameter MULT_W = 6,
  parameter LB_W = 4
) (
  // Clock and reset; clk_in is the bus clock
  input wire clk_in,
  input wire resetn_in,
  // Double-rate memory controller clock from the PLL
  input wire mem_ctrl_clk_in,
  // APB slave
  input wire psel_in,
  input wire penable_in,
  input wire pwrite_in,
  input wire [11:0] paddr_in,
  input wire [31:0] pwdata_in,
  output wire pready_out,
  output wire pslverr_out,
  output reg [31:0] prdata_out,
  // Reset configuration straps
  input wire pci_primary_in,
  input wire input_divide_strap_in,
  input wire [MULT_W-1:0] engine_pll_multiplier_in,
  input wire [1:0] engine_pll_divider_in,
  // Input frequency in MHz and core ratio in half steps
  input wire [15:0] primary_input_mhz_in,
  input wire [2:0] core_ratio_x2_in,
  // Memory bus clock pair and data strobe enable
  output reg memory_bus_clock_out,
  output reg memory_bus_clock_n_out,
  output reg mem_data_strobe_out,
  // Local bus clocks
  output wire lbc_clk_en_out,
  output reg local_bus_sync_clock_out,
  output reg [2:0] local_bus_clock_outs,
  // Unit clock enables
  output wire sec_clk_en_out,
  output wire i2c_clk_en_out,
  output wire aux_unit_a_clk_en_out,
  output wire aux_unit_b_clk_en_out,
  output reg pci_dma_clk_en_out,
  // Engine frequency and limit violation flag
  output reg [15:0] engine_mhz_out,
  output reg freq_violation_out
);

  // ----------------------------------------
  // Registers
  // ----------------------------------------
  localparam STRAP_W = MULT_W + 4;
  reg [8:0] units_r;
  reg [LB_W-1:0] lb_div_r;
  reg [MULT_W-1:0] mult_r;
  reg [1:0] div_r;
  reg pci_prim_r;
  reg strap_r;
  reg straps_taken_r;
  reg [15:0] engine_nxt;
  reg [15:0] core_mhz_r;
  reg mem_half_r;
  reg [STRAP_W-1:0] strap_s1_r;
  reg [STRAP_W-1:0] strap_s2_r;
  reg [STRAP_W-1:0] strap_s3_r;
  wire [STRAP_W-1:0] strap_pins;
  wire strap_stable;
  wire [18:0] core_prod;
  wire wr_units;
  wire wr_lb;
  wire wr_cfg;
  wire lb_div_clk;
  wire wr_en;
  wire rd_en;
  wire addr_ok;

  function [15:0] engine_freq;
    input [15:0] fin;
    input [MULT_W-1:0] m;
    input [1:0] d;
    input pci;
    input strap;
    reg [31:0] prod;
    reg [31:0] quot;
    begin
      prod = fin * m;
      if (pci)
        prod = prod * (32'h1 + {31'h0, ~strap});
      quot = prod / ({30'h0, d} + 32'h1);
      // Whole MHz only; fractions are dropped
      engine_freq = quot[15:0];
    end
  endfunction

  // Register select, shared by decode and write strobes
  function reg_hit;
    input [11:0] addr;
    input [11:0] off;
    begin
      reg_hit = (addr == off);
    end
  endfunction

  // One two-bit selection field of the unit register
  function [1:0] unit_field;
    input [8:0] units;
    input integer lsb;
    begin
      unit_field = units[lsb +: 2];
    end
  endfunction

  // Strict compare; a value equal to the limit is allowed
  function over_limit;
    input [15:0] mhz;
    input [15:0] max_mhz;
    begin
      over_limit = (mhz > max_mhz);
    end
  endfunction

  // ----------------------------------------
  // APB decode
  // ----------------------------------------
  assign addr_ok = reg_hit(paddr_in, `OFF_SYSTEM_CLOCK_CONTROL_REGISTER_UNITS) ||
                   reg_hit(paddr_in, `OFF_LB_RATIO) ||
                   reg_hit(paddr_in, `OFF_ENGINE_CFG) ||
                   reg_hit(paddr_in, `OFF_ENGINE_FREQ) ||
                   reg_hit(paddr_in, `OFF_STATUS);
  // No wait states: every register answers in the access phase
  assign pready_out = 1'b1;
  assign pslverr_out = psel_in && penable_in && !addr_ok;
  assign wr_en = psel_in && penable_in && pwrite_in && addr_ok;
  assign rd_en = psel_in && !penable_in && !pwrite_in;
  assign wr_units = wr_en && reg_hit(paddr_in, `OFF_SYSTEM_CLOCK_CONTROL_REGISTER_UNITS);
  assign wr_lb = wr_en && reg_hit(paddr_in, `OFF_LB_RATIO);
  assign wr_cfg = wr_en && reg_hit(paddr_in, `OFF_ENGINE_CFG);

  // ----------------------------------------
  // Strap synchroniser
  // ----------------------------------------
  assign strap_pins = {pci_primary_in, input_divide_strap_in,
                       engine_pll_multiplier_in, engine_pll_divider_in};
  assign strap_stable = (strap_s2_r == strap_s3_r);
  // Three stages as for any pin; no reset on the chain, so it
  // fills while reset is held and the straps already stand
  always @(posedge clk_in) begin
    strap_s1_r <= strap_pins;
    strap_s2_r <= strap_s1_r;
    strap_s3_r <= strap_s2_r;
  end

  // ----------------------------------------
  // Register writes and straps
  // ----------------------------------------
  // defaults then software writes
  always @(posedge clk_in or negedge resetn_in) begin
    if (!resetn_in) begin
      units_r <= `RST_UNITS;
      lb_div_r <= `RST_LB_DIV;
      mult_r <= `RST_MULT;
      div_r <= `RST_DIV;
      pci_prim_r <= 1'b0;
      strap_r <= 1'b0;
      straps_taken_r <= 1'b0;
    end else begin
      // Straps taken once after release, as soon as they agree;
      // a config write before that is dropped
      if (!straps_taken_r) begin
        if (strap_stable) begin
          straps_taken_r <= 1'b1;
          pci_prim_r <= strap_s3_r[STRAP_W-1];
          strap_r <= strap_s3_r[STRAP_W-2];
          mult_r <= strap_s3_r[MULT_W+1:2];
          div_r <= strap_s3_r[1:0];
        end
      end else if (wr_cfg) begin
        mult_r <= pwdata_in[MULT_W-1:0];
        div_r <= pwdata_in[9:8];
      end
      if (wr_units)
        units_r <= pwdata_in[8:0];
      if (wr_lb)
        lb_div_r <= pwdata_in[LB_W-1:0];
    end
  end

  // ----------------------------------------
  // Read data
  // ----------------------------------------
  // Loaded at the end of setup, so it stands through the access
  always @(posedge clk_in or negedge resetn_in) begin
    if (!resetn_in) begin
      prdata_out <= 32'h0;
    end else if (rd_en) begin
      case (paddr_in)
        `OFF_SYSTEM_CLOCK_CONTROL_REGISTER_UNITS: prdata_out <= {23'h0, units_r};
        `OFF_LB_RATIO: prdata_out <= {{(32-LB_W){1'b0}}, lb_div_r};
        `OFF_ENGINE_CFG:
          prdata_out <= {16'h0, 6'h0, div_r, {(8-MULT_W){1'b0}}, mult_r};
        `OFF_ENGINE_FREQ: prdata_out <= {16'h0, engine_mhz_out};
        `OFF_STATUS:
          prdata_out <= {28'h0, freq_violation_out, strap_r,
                         pci_prim_r, straps_taken_r};
        default: prdata_out <= 32'h0;
      endcase
    end
  end

  // ----------------------------------------
  // Engine frequency and limits
  // ----------------------------------------
  always @* begin
    engine_nxt = engine_freq(primary_input_mhz_in, mult_r, div_r,
                             pci_prim_r, strap_r);
  end

  // Wide product so a fast input cannot wrap before the halving
  assign core_prod = primary_input_mhz_in * core_ratio_x2_in;

  // frequency limit check
  // Flag only; the PLL itself cannot be stopped from here
  always @(posedge clk_in or negedge resetn_in) begin
    if (!resetn_in) begin
      engine_mhz_out <= 16'h0;
      core_mhz_r <= 16'h0;
      freq_violation_out <= 1'b0;
    end else begin
      engine_mhz_out <= engine_nxt;
      core_mhz_r <= core_prod[16:1];
      freq_violation_out <= over_limit(engine_mhz_out, `MAX_ENGINE_MHZ) ||
                            over_limit(core_mhz_r, `MAX_CORE_MHZ) ||
                            over_limit(primary_input_mhz_in, `MAX_CSB_MHZ);
    end
  end

  // ----------------------------------------
  // Memory bus clock
  // ----------------------------------------
  // Reset release is not synchronised to this clock; the two
  // clocks must not have edges together at release
  // controller clock is twice bus clock, supplied by PLL
  always @(posedge mem_ctrl_clk_in or negedge resetn_in) begin
    if (!resetn_in) begin
      mem_half_r <= 1'b0;
      memory_bus_clock_out <= 1'b0;
      memory_bus_clock_n_out <= 1'b1;
      mem_data_strobe_out <= 1'b0;
    end else begin
      mem_half_r <= ~mem_half_r;
      memory_bus_clock_out <= ~mem_half_r;
      memory_bus_clock_n_out <= mem_half_r;
      mem_data_strobe_out <= 1'b1;
    end
  end

  // ----------------------------------------
  // Local bus clocks
  // ----------------------------------------
  // Controller runs straight off the bus clock, no divider
  // controller on bus clock
  assign lbc_clk_en_out = resetn_in;

  lb_clk_div #(.WIDTH(LB_W)) u_lb_div (
    .clk_in(clk_in),
    .resetn_in(resetn_in),
    .div_in(lb_div_r),
    .clk_div_out(lb_div_clk)
  );

  always @(posedge clk_in or negedge resetn_in) begin
    if (!resetn_in) begin
      local_bus_sync_clock_out <= 1'b0;
      local_bus_clock_outs <= 3'h0;
    end else begin
      local_bus_sync_clock_out <= lb_div_clk;
      local_bus_clock_outs <= {3{lb_div_clk}};
    end
  end

  // ----------------------------------------
  // Unit clock enables
  // ----------------------------------------
  // software must program before access; not enforced here
  unit_clk_div u_sec (
    .clk_in(clk_in),
    .resetn_in(resetn_in),
    .sel_in(unit_field(units_r, `F_SEC_LSB)),
    .en_out(sec_clk_en_out)
  );

  unit_clk_div u_i2c (
    .clk_in(clk_in),
    .resetn_in(resetn_in),
    .sel_in(unit_field(units_r, `F_I2C_LSB)),
    .en_out(i2c_clk_en_out)
  );

  unit_clk_div u_auxa (
    .clk_in(clk_in),
    .resetn_in(resetn_in),
    .sel_in(unit_field(units_r, `F_AUXA_LSB)),
    .en_out(aux_unit_a_clk_en_out)
  );

  unit_clk_div u_auxb (
    .clk_in(clk_in),
    .resetn_in(resetn_in),
    .sel_in(unit_field(units_r, `F_AUXB_LSB)),
    .en_out(aux_unit_b_clk_en_out)
  );

  always @(posedge clk_in or negedge resetn_in) begin
    if (!resetn_in)
      pci_dma_clk_en_out <= 1'b0;
    else
      pci_dma_clk_en_out <= !units_r[`F_PCI_BIT];
  end

endmodule // system_clock_ratio_control
`default_nettype wire

// ### tb_system_clock_ratio_control.sv
// Self-checking testbench for the clock ratio control block
`timescale 1ns/10ps
`default_nettype none
module tb_system_clock_ratio_control;
  logic clk_in = 1'h0, resetn_in = 1'h0, mem_ctrl_clk_in;
  logic psel_in = 1'h0, penable_in = 1'h0, pwrite_in = 1'h0;
  logic [11:0] paddr_in = 12'h000;
  logic [31:0] pwdata_in = 32'h0, prdata_out, q, v;
  logic pready_out, pslverr_out, pci_primary_in = 1'h0, strap = 1'h0;
  logic [5:0] mult = 6'h00;
  logic [1:0] div = 2'h0;
  logic [15:0] fin = 16'h0000, engine_mhz_out;
  logic [2:0] local_bus_clock_outs;
  logic [2:0] cr = 3'h4;
  logic mbc, mbc_n, strobe, lbc_en, lb_sync, viol, pci_en;
  logic sec_en, i2c_en, aux_a_en, aux_b_en;
  int err_count = 0, cmp_count = 0, mbc_cnt = 0, lb_cnt = 0, n0;
  int cnt [4];
  int lbr [4] = '{1, 2, 3, 5};
  always #10 clk_in = ~clk_in;
  always @(posedge mbc) mbc_cnt++;
  always @(posedge lb_sync) lb_cnt++;
  pll_model i_pll_model (.mem_clk_out(mem_ctrl_clk_in));
  system_clock_ratio_control i_system_clock_ratio_control (
    .clk_in(clk_in), .resetn_in(resetn_in), .mem_ctrl_clk_in(mem_ctrl_clk_in),
    .psel_in(psel_in), .penable_in(penable_in), .pwrite_in(pwrite_in),
    .paddr_in(paddr_in), .pwdata_in(pwdata_in), .pready_out(pready_out),
    .pslverr_out(pslverr_out), .prdata_out(prdata_out),
    .pci_primary_in(pci_primary_in), .input_divide_strap_in(strap),
    .engine_pll_multiplier_in(mult), .engine_pll_divider_in(div),
    .primary_input_mhz_in(fin), .core_ratio_x2_in(cr),
    .memory_bus_clock_out(mbc), .memory_bus_clock_n_out(mbc_n),
    .mem_data_strobe_out(strobe), .lbc_clk_en_out(lbc_en),
    .local_bus_sync_clock_out(lb_sync),
    .local_bus_clock_outs(local_bus_clock_outs),
    .sec_clk_en_out(sec_en), .i2c_clk_en_out(i2c_en),
    .aux_unit_a_clk_en_out(aux_a_en), .aux_unit_b_clk_en_out(aux_b_en),
    .pci_dma_clk_en_out(pci_en), .engine_mhz_out(engine_mhz_out),
    .freq_violation_out(viol));
  task automatic chk(input string nm, input logic [31:0] seen, exp);
    cmp_count++;
    if (seen !== exp) begin
      err_count++;
      $display("mismatch %s expected %h seen %h", nm, exp, seen);
    end
  endtask
  task automatic close_out();
    if (err_count == 0 && cmp_count > 0) begin
      $display("Testbench passed");
    end else begin
      $display("Testbench failed");
    end
    $finish;
  endtask
  // Setup, then hold the access until pready is sampled high
  task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
    int n;
    @(posedge clk_in);
    psel_in <= 1'h1;
    pwrite_in <= w;
    paddr_in <= a;
    pwdata_in <= d;
    @(posedge clk_in);
    penable_in <= 1'h1;
    n = 0;
    do begin
      @(posedge clk_in);
      n++;
    end while (pready_out !== 1'h1 && n < 16);
    q = prdata_out;
    psel_in <= 1'h0;
    penable_in <= 1'h0;
    if (pready_out !== 1'h1) begin
      err_count++;
      close_out();
    end
  endtask
  task automatic rd(input logic [11:0] a, input logic [31:0] e);
    apb(1'h0, a, 32'h0);
    chk("read data", q, e);
  endtask
  // Straps are held across reset and taken after release, once the synchroniser stages agree
  task automatic eng(input logic p, s, input logic [5:0] m,
      input logic [1:0] d, input logic [15:0] f, e, input logic vx);
    @(posedge clk_in);
    resetn_in <= 1'h0;
    pci_primary_in <= p;
    strap <= s;
    mult <= m;
    div <= d;
    fin <= f;
    repeat (2) @(posedge clk_in);
    resetn_in <= 1'h1;
    // Straps pass a three-stage synchroniser before they are taken
    repeat (6) @(posedge clk_in);
    chk("engine mhz", engine_mhz_out, e);
    chk("violation", viol, vx);
    rd(12'h00c, {16'h0, e});
    rd(12'h010, {28'h0, vx, s, p, 1'h1});
    rd(12'h008, {22'h0, d, 2'h0, m});
    rd(12'h000, 32'h0);
    rd(12'h004, 32'h2);
  endtask
  initial begin
    eng(1'h0, 1'h0, 6'h06, 2'h1, 16'h0042, 16'h00c6, 1'h0);
    for (int c = 0; c < 4; c++) begin
      v = {23'h0, c[0], {4{c[1:0]}}};
      apb(1'h1, 12'h000, v);
      repeat (8) @(posedge clk_in);
      cnt = '{0, 0, 0, 0};
      repeat (12) begin
        @(posedge clk_in);
        cnt[0] += sec_en;
        cnt[1] += i2c_en;
        cnt[2] += aux_a_en;
        cnt[3] += aux_b_en;
      end
      for (int u = 0; u < 4; u++) begin
        chk("unit pulses", cnt[u], c == 0 ? 12 : c == 1 ? 0 : 12 / c);
      end
      chk("pci enable", pci_en, !c[0]);
      rd(12'h000, v);
    end
    foreach (lbr[i]) begin
      apb(1'h1, 12'h004, lbr[i]);
      repeat (8) @(posedge clk_in);
      n0 = lb_cnt;
      repeat (60) @(posedge clk_in);
      chk("lb edges", lb_cnt - n0, 60 / (lbr[i] < 2 ? 2 : lbr[i]));
    end
    // Counted on the falling edge, clear of both clocks' rising edges
    @(negedge clk_in);
    n0 = mbc_cnt;
    repeat (40) @(negedge clk_in);
    chk("mem bus edges", mbc_cnt - n0, 40);
    apb(1'h1, 12'h020, 32'hffffffff);
    rd(12'h020, 32'h0);
    rd(12'h000, 32'h000001ff);
    rd(12'h004, 32'h00000005);
    eng(1'h1, 1'h0, 6'h06, 2'h2, 16'h0032, 16'h00c8, 1'h0);
    eng(1'h1, 1'h1, 6'h07, 2'h0, 16'h0028, 16'h0118, 1'h1);
    eng(1'h0, 1'h0, 6'h01, 2'h3, 16'h0064, 16'h0019, 1'h0);
    // Core over its limit alone, then the bus over its limit alone
    cr <= 3'h7;
    repeat (4) @(posedge clk_in);
    chk("core limit", viol, 1'h1);
    cr <= 3'h4;
    fin <= 16'h0086;
    repeat (4) @(posedge clk_in);
    chk("bus limit", viol, 1'h1);
    apb(1'h1, 12'h008, 32'h00000105);
    repeat (3) @(posedge clk_in);
    chk("engine cfg", engine_mhz_out, 16'h014f);
    rd(12'h008, 32'h00000105);
    close_out();
  end
endmodule // tb_system_clock_ratio_control
`default_nettype wire

// ### unit_clk_div.v
// Glitch-free divide-by-1/2/3/off enable generator for one unit
`timescale 1ns/10ps
`default_nettype none
`include "clk_ratio_consts.vh"

module unit_clk_div (
  // Clock and reset
  input wire clk_in,
  input wire resetn_in,
  // Selection
  input wire [1:0] sel_in,
  // Unit clock enable pulse, one per divided period
  output reg en_out
);

  reg [1:0] cnt_r;
  reg [1:0] sel_r;
  wire wrap;

  assign wrap = (sel_r == `SEL_DIV3) ? (cnt_r == 2'h2) :
                (sel_r == `SEL_DIV2) ? (cnt_r == 2'h1) : 1'b1;

  // ----------------------------------------
  // Divider
  // ----------------------------------------
  // switch only at boundary
  // New selection taken at a period end, so no runt enable appears
  always @(posedge clk_in or negedge resetn_in) begin
    if (!resetn_in) begin
      cnt_r <= 2'h0;
      sel_r <= `SEL_CSB;
      en_out <= 1'b0;
    end else begin
      if (wrap) begin
        cnt_r <= 2'h0;
        sel_r <= sel_in;
      end else begin
        cnt_r <= cnt_r + 2'h1;
      end
      en_out <= wrap && (sel_r != `SEL_OFF);
    end
  end

endmodule // unit_clk_div
`default_nettype wire
